/* File: logic/core_exception_entry_unit.sv */
// Exception entry unit: machine check, checkstop, storage, external
// input and alignment entry, with a classic Wishbone register slave.
// Assumes fault pulses come from same-clock pipeline logic; pins are
// synchronised here.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "exc_consts.svh"
module core_exception_entry_unit
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire exc_pkg::word_t wb_dat_i,
  output exc_pkg::word_t wb_dat_o,
  output logic wb_ack_o,
  // Pins from the system (asynchronous)
  input wire logic mchk_pin_n_i,
  input wire logic ext_irq_n_i,
  input wire logic avec_n_i,
  input wire logic [9:0] voffset_i,
  input wire logic dbg_req_i,
  // Debug controller, same clock
  input wire logic dbg_exit_i,
  // Pipeline addresses
  input wire exc_pkg::word_t exc_pc_i,
  input wire exc_pkg::word_t next_pc_i,
  input wire exc_pkg::word_t d_addr_i,
  // Data side fault pulses
  input wire logic dacc_viol_i,
  input wire logic dbyteord_i,
  input wire logic dtea_i,
  input wire logic d_store_i,
  input wire logic d_varlen_i,
  input wire logic align_fault_i,
  // Instruction side fault pulses
  input wire logic iacc_viol_i,
  input wire logic itea_i,
  input wire logic ibyteord_i,
  input wire logic imisalign_i,
  input wire logic i_varlen_i,
  // Machine check sources and watchdog
  input wire logic handler_fetch_err_i,
  input wire logic store_bus_err_i,
  input wire logic wdog_second_i,
  // Outputs toward pipeline and system
  output logic exc_taken_o,
  output exc_pkg::word_t handler_pc_o,
  output logic halt_o,
  output logic chkstop_o,
  output logic wakeup_o,
  output logic dbg_session_o,
  output logic mchk_out_o,
  output logic reset_out_n_o
);
  import exc_pkg::*;

  // ==================================================
  // Helpers
  // Byte-lane merge of a bus write
  function automatic word_t merge(input word_t old, input word_t wd,
                                  input logic [3:0] sel);
    word_t r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Prefix plus low offset
  function automatic word_t vec(input word_t pfx, input logic [11:0] o);
    return {pfx[31:`PFX_LO], o};
  endfunction

  // ==================================================
  // Pin synchronisers
  logic [13:0] sync1; // First stage, read only by second
  logic [13:0] sync2; // Stable copies
  logic [13:0] next_sync1;
  logic [13:0] next_sync2;
  logic mchk_pin; // Active high, synchronised
  logic ext_req; // Active high, synchronised
  logic avec; // Active high, synchronised
  logic [9:0] voff;
  logic dbg_req;

  // Two flops per pin; active-low pins inverted after the chain
  always_comb
  begin
    next_sync1 = sync1;
    next_sync2 = sync2;
    if (ce_i)
    begin
      next_sync1 = {mchk_pin_n_i, ext_irq_n_i, avec_n_i, voffset_i,
                    dbg_req_i};
      next_sync2 = sync1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 14'h3c00;
      sync2 <= 14'h3c00;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign mchk_pin = ~sync2[13];
  assign ext_req = ~sync2[12];
  assign avec = ~sync2[11];
  assign voff = sync2[10:1];
  assign dbg_req = sync2[0];

  // ==================================================
  // Architectural registers and checkstop state
  word_t mstate, cspc, csstate, spc, sstate, fstat, faddr, vpfx;
  word_t synd, cfg, tctl, dctl;
  word_t next_mstate, next_cspc, next_csstate, next_spc, next_sstate;
  word_t next_fstat, next_faddr, next_vpfx, next_synd, next_cfg;
  word_t next_tctl, next_dctl, next_hpc;
  cpu_state_e state, next_state;
  logic next_taken;
  logic ack, next_ack;
  word_t rdat, next_rdat;

  // Decoded events, all in the current cycle
  logic me, ee; // Enables from machine state
  logic bus_req; // Request not yet answered
  logic bus_wr; // Write taking effect this edge
  word_t src; // Machine check sources as syndrome bits
  logic mchk_any; // Any machine check source
  logic instr_storage_fault, dsi, ext_go;
  logic go_chk; // Checkstop entry this cycle
  logic running;

  assign me = mstate[`MS_ME];
  assign ee = mstate[`MS_EE];
  assign running = (state == ST_RUN);
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack;
  // Write lands at the edge where the master samples ack high
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack;

  // Source vector; precise bus errors with external enable clear
  // escalate to machine check sources rather than storage faults
  always_comb
  begin
    src = 32'h0;
    src[`SY_PIN] = mchk_pin & cfg[`CFG_PIN_EN];
    src[`SY_EXCP] = handler_fetch_err_i;
    src[`SY_IRERR] = itea_i & ~ee;
    src[`SY_DRERR] = dtea_i & ~ee;
    src[`SY_WRERR] = store_bus_err_i;
  end

  assign mchk_any = |src;
  assign instr_storage_fault = iacc_viol_i | (itea_i & ee) | ibyteord_i | imisalign_i;
  assign dsi = dacc_viol_i | dbyteord_i | (dtea_i & ee);
  assign ext_go = ext_req & ee;
  // Disabled machine check or watchdog escalation
  assign go_chk = running & ((mchk_any & ~me) |
                  (wdog_second_i &
                   (tctl[`TCTL_WRC_HI:`TCTL_WRC_LO] == `WRC_CHKSTOP)));

  // Next state of every architectural register; one entry per cycle
  // in fixed priority, hardware entry beats a same-cycle bus write
  always_comb
  begin
    next_mstate = mstate;
    next_cspc = cspc;
    next_csstate = csstate;
    next_spc = spc;
    next_sstate = sstate;
    next_fstat = fstat;
    next_faddr = faddr;
    next_vpfx = vpfx;
    next_synd = synd;
    next_cfg = cfg;
    next_tctl = tctl;
    next_dctl = dctl;
    next_hpc = handler_pc_o;
    next_taken = 1'b0;
    next_state = state;
    // Software writes first, so hardware below overrides them
    if (bus_wr)
    begin
      unique case (wb_adr_i)
        `OFS_MSTATE: next_mstate = merge(mstate, wb_dat_i, wb_sel_i) &
                                   `MS_IMPL;
        `OFS_CSPC: next_cspc = merge(cspc, wb_dat_i, wb_sel_i);
        `OFS_CSSTATE: next_csstate = merge(csstate, wb_dat_i, wb_sel_i);
        `OFS_SPC: next_spc = merge(spc, wb_dat_i, wb_sel_i);
        `OFS_SSTATE: next_sstate = merge(sstate, wb_dat_i, wb_sel_i);
        `OFS_FSTAT: next_fstat = merge(fstat, wb_dat_i, wb_sel_i);
        `OFS_FADDR: next_faddr = merge(faddr, wb_dat_i, wb_sel_i);
        `OFS_VPFX: next_vpfx = merge(vpfx, wb_dat_i, wb_sel_i) &
                               32'hffff_f000;
        // Write one to clear a syndrome bit
        `OFS_SYND: next_synd = synd & ~merge(32'h0, wb_dat_i, wb_sel_i);
        `OFS_CFG: next_cfg = merge(cfg, wb_dat_i, wb_sel_i) & 32'h3;
        `OFS_TCTL: next_tctl = merge(tctl, wb_dat_i, wb_sel_i);
        `OFS_DCTL: next_dctl = merge(dctl, wb_dat_i, wb_sel_i) & 32'h3;
        default: ; // Unmapped and status: write ignored
      endcase
    end
    if (running)
    begin
      // Priority: machine check, instruction, data, alignment, external
      if (mchk_any & me)
      begin
        next_csstate = mstate;
        next_cspc = exc_pc_i;
        next_mstate = mstate & ~`MS_CLR_MCHK;
        if (~dctl[`DCTL_DBG_EN] | cfg[`CFG_MCLR_DE])
        begin
          next_mstate[`MS_DE] = 1'b0;
        end
        next_synd = next_synd | src;
        next_hpc = vec(vpfx, `VOFS_MCHK);
        next_taken = 1'b1;
      end
      else if (instr_storage_fault)
      begin
        next_sstate = mstate;
        next_mstate = mstate & ~`MS_CLR_NONCRIT;
        next_spc = exc_pc_i;
        next_fstat = 32'h0;
        next_fstat[`FS_XTE] = itea_i;
        next_fstat[`FS_BO] = ibyteord_i;
        next_fstat[`FS_MIF] = imisalign_i;
        next_fstat[`FS_VARLEN_INSTR_FLAG] = i_varlen_i;
        next_hpc = vec(vpfx, `VOFS_ISI);
        next_taken = 1'b1;
      end
      else if (dsi | align_fault_i)
      begin
        next_sstate = mstate;
        next_mstate = mstate & ~`MS_CLR_NONCRIT;
        next_spc = exc_pc_i;
        next_fstat = 32'h0;
        next_fstat[`FS_ST] = d_store_i;
        next_fstat[`FS_VARLEN_INSTR_FLAG] = d_varlen_i;
        if (dsi)
        begin
          // Byte order and external error only on data storage fault
          next_fstat[`FS_BO] = dbyteord_i & ~dacc_viol_i;
          next_fstat[`FS_XTE] = dtea_i & ~dacc_viol_i & ~dbyteord_i;
          if (dacc_viol_i | dbyteord_i)
          begin
            next_faddr = d_addr_i;
          end
          next_hpc = vec(vpfx, `VOFS_DSI);
        end
        else
        begin
          next_faddr = d_addr_i;
          next_hpc = vec(vpfx, `VOFS_ALIGN);
        end
        next_taken = 1'b1;
      end
      else if (ext_go)
      begin
        next_sstate = mstate;
        next_mstate = mstate & ~`MS_CLR_NONCRIT;
        next_spc = next_pc_i;
        if (avec)
        begin
          next_hpc = vec(vpfx, `VOFS_EXT);
        end
        else
        begin
          next_hpc = vec(vpfx, {voff, 2'b00});
        end
        next_taken = 1'b1;
      end
    end
    // Checkstop and debug escape
    unique case (state)
      ST_RUN:
      begin
        if (go_chk)
        begin
          next_state = ST_CHKSTOP;
          next_synd = next_synd | src;
        end
      end
      ST_CHKSTOP:
      begin
        // Next edge proves the clock runs again
        if (dbg_req)
        begin
          next_state = ST_DEBUG;
        end
      end
      ST_DEBUG:
      begin
        if (dbg_exit_i)
        begin
          next_state = ST_CHKSTOP;
        end
      end
      default: next_state = ST_CHKSTOP; // Illegal code: stay halted
    endcase
  end

  // Register all architectural state; reset only leaves checkstop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mstate <= 32'h0;
      cspc <= 32'h0;
      csstate <= 32'h0;
      spc <= 32'h0;
      sstate <= 32'h0;
      fstat <= 32'h0;
      faddr <= 32'h0;
      vpfx <= 32'h0;
      synd <= 32'h0;
      cfg <= 32'h0;
      tctl <= 32'h0;
      dctl <= 32'h0;
      handler_pc_o <= 32'h0;
      exc_taken_o <= 1'b0;
      state <= ST_RUN;
    end
    else if (ce_i)
    begin
      mstate <= next_mstate;
      cspc <= next_cspc;
      csstate <= next_csstate;
      spc <= next_spc;
      sstate <= next_sstate;
      fstat <= next_fstat;
      faddr <= next_faddr;
      vpfx <= next_vpfx;
      synd <= next_synd & `SY_IMPL;
      cfg <= next_cfg;
      tctl <= next_tctl;
      dctl <= next_dctl;
      handler_pc_o <= next_hpc;
      exc_taken_o <= next_taken;
      state <= next_state;
    end
    else
    begin
      exc_taken_o <= exc_taken_o;
    end
  end

  // ==================================================
  // Wishbone answer: ack one cycle after the request, read data
  // registered with it so the master sees a stable word
  always_comb
  begin
    next_ack = 1'b0;
    next_rdat = rdat;
    if (ce_i)
    begin
      next_ack = bus_req;
    end
    else
    begin
      next_ack = ack;
    end
    if (ce_i & bus_req & ~wb_we_i)
    begin
      unique case (wb_adr_i)
        `OFS_MSTATE: next_rdat = mstate;
        `OFS_CSPC: next_rdat = cspc;
        `OFS_CSSTATE: next_rdat = csstate;
        `OFS_SPC: next_rdat = spc;
        `OFS_SSTATE: next_rdat = sstate;
        `OFS_FSTAT: next_rdat = fstat;
        `OFS_FADDR: next_rdat = faddr;
        `OFS_VPFX: next_rdat = vpfx;
        `OFS_SYND: next_rdat = synd;
        `OFS_CFG: next_rdat = cfg;
        `OFS_TCTL: next_rdat = tctl;
        `OFS_DCTL: next_rdat = dctl;
        `OFS_STAT: next_rdat = {29'h0, wakeup_o, dbg_session_o, chkstop_o};
        default: next_rdat = 32'h0; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rdat <= 32'h0;
    end
    else
    begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;

  // ==================================================
  // System indications
  assign chkstop_o = (state == ST_CHKSTOP);
  assign halt_o = ~running;
  assign dbg_session_o = (state == ST_DEBUG);
  assign wakeup_o = (state == ST_CHKSTOP) & dbg_req;
  assign mchk_out_o = |synd;
  // Works in any state, checkstop included
  assign reset_out_n_o = ~dctl[`DCTL_RST];

endmodule

/* File: logic/exc_consts.svh */
// Named offsets, bit positions and codes for the exception entry unit.
// Assumes inclusion by bare name from the package and the unit.
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH
// ==================================================
// Register byte offsets
`define OFS_MSTATE 8'h00
`define OFS_CSPC 8'h04
`define OFS_CSSTATE 8'h08
`define OFS_SPC 8'h0c
`define OFS_SSTATE 8'h10
`define OFS_FSTAT 8'h14
`define OFS_FADDR 8'h18
`define OFS_VPFX 8'h1c
`define OFS_SYND 8'h20
`define OFS_CFG 8'h24
`define OFS_TCTL 8'h28
`define OFS_DCTL 8'h2c
`define OFS_STAT 8'h30
// ==================================================
// Machine state bits and masks
`define MS_EE 15
`define MS_ME 12
`define MS_DE 9
`define MS_IMPL 32'h0006_f230
`define MS_CLR_MCHK 32'h0006_f030
`define MS_CLR_NONCRIT 32'h0004_e030
// ==================================================
// Fault status flag positions
`define FS_XTE 0
`define FS_MIF 1
`define FS_VARLEN_INSTR_FLAG 5
`define FS_BO 17
`define FS_ST 23
// ==================================================
// Syndrome bit positions
`define SY_PIN 31
`define SY_EXCP 27
`define SY_IRERR 4
`define SY_DRERR 3
`define SY_WRERR 2
`define SY_IMPL 32'h8800_001c
// ==================================================
// Config and control bits, vector offsets
`define CFG_PIN_EN 0
`define CFG_MCLR_DE 1
`define DCTL_RST 0
`define DCTL_DBG_EN 1
`define TCTL_WRC_HI 29
`define TCTL_WRC_LO 28
`define WRC_CHKSTOP 2'h1
`define VOFS_MCHK 12'h010
`define VOFS_DSI 12'h020
`define VOFS_ISI 12'h030
`define VOFS_EXT 12'h040
`define VOFS_ALIGN 12'h050
`define PFX_LO 12
`endif

/* File: logic/exc_pkg.sv */
// Types shared by the exception entry unit.
// Assumes the constants header is on the include path.
`include "exc_consts.svh"
package exc_pkg;
  // Run / checkstop / debug-escape state
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_CHKSTOP = 2'b01,
    ST_DEBUG = 2'b10
  } cpu_state_e;
  typedef logic [31:0] word_t;
endpackage

/* File: testbench/exc_unit_properties.sv */
// Concurrent checks on the ports of the exception entry unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "exc_consts.svh"
module exc_unit_properties
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Causes seen by the unit
  input wire logic ce_i,
  input wire logic mchk_pin_n_i,
  input wire logic dacc_viol_i,
  input wire logic dbyteord_i,
  input wire logic dtea_i,
  input wire logic align_fault_i,
  input wire logic iacc_viol_i,
  input wire logic itea_i,
  input wire logic ibyteord_i,
  input wire logic imisalign_i,
  input wire logic handler_fetch_err_i,
  input wire logic store_bus_err_i,
  input wire logic wdog_second_i,
  input wire logic dbg_exit_i,
  // Results driven by the unit
  input wire logic exc_taken_o,
  input wire exc_pkg::word_t handler_pc_o,
  input wire logic halt_o,
  input wire logic chkstop_o,
  input wire logic wakeup_o,
  input wire logic dbg_session_o
);
  import exc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==================================================
  // Sequences
  // No machine check source; pin history covers the sync delay
  sequence s_no_mchk;
    !(handler_fetch_err_i || store_bus_err_i || wdog_second_i || itea_i
      || dtea_i)
      && &{mchk_pin_n_i, $past(mchk_pin_n_i), $past(mchk_pin_n_i, 2),
      $past(mchk_pin_n_i, 3)};
  endsequence
  // Running, no instruction side fault competing
  sequence s_run_data;
    ce_i && !halt_o && !(iacc_viol_i || ibyteord_i || imisalign_i)
      ##0 s_no_mchk;
  endsequence
  // ==================================================
  // Assertions
  AST_ISI_VEC: assert property (
    ce_i && !halt_o && iacc_viol_i ##0 s_no_mchk
      |=> exc_taken_o && handler_pc_o[11:0] == `VOFS_ISI)
    else $error("instruction fault entry wrong");
  AST_DSI_VEC: assert property (
    s_run_data ##0 dacc_viol_i
      |=> exc_taken_o && handler_pc_o[11:0] == `VOFS_DSI)
    else $error("data fault entry wrong");
  AST_ALIGN_VEC: assert property (
    s_run_data ##0 align_fault_i && !dacc_viol_i && !dbyteord_i && !dtea_i
      |=> exc_taken_o && handler_pc_o[11:0] == `VOFS_ALIGN)
    else $error("alignment entry wrong");
  AST_STORE_ERR: assert property (
    ce_i && !halt_o && store_bus_err_i
      |=> (exc_taken_o && handler_pc_o[11:0] == `VOFS_MCHK)
      || (chkstop_o && !exc_taken_o))
    else $error("store bus error neither taken nor checkstop");
  AST_NO_ENTRY_HALT: assert property (
    halt_o |=> !exc_taken_o)
    else $error("entry while halted");
  AST_CHK_HOLD: assert property (
    chkstop_o |-> halt_o ##1 (chkstop_o || dbg_session_o))
    else $error("checkstop left without reset");
  AST_DBG_NEG: assert property (
    dbg_session_o |-> !chkstop_o && halt_o)
    else $error("checkstop shown during debug");
  AST_DBG_BACK: assert property (
    ce_i && dbg_session_o && dbg_exit_i |=> chkstop_o && !dbg_session_o)
    else $error("no return to checkstop");
  AST_WAKE: assert property (
    ce_i && wakeup_o |-> chkstop_o ##1 dbg_session_o)
    else $error("wakeup without debug entry");
endmodule
bind core_exception_entry_unit exc_unit_properties chk
(
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mchk_pin_n_i(mchk_pin_n_i),
  .dacc_viol_i(dacc_viol_i), .dbyteord_i(dbyteord_i), .dtea_i(dtea_i),
  .align_fault_i(align_fault_i), .iacc_viol_i(iacc_viol_i),
  .itea_i(itea_i), .ibyteord_i(ibyteord_i), .imisalign_i(imisalign_i),
  .handler_fetch_err_i(handler_fetch_err_i),
  .store_bus_err_i(store_bus_err_i), .wdog_second_i(wdog_second_i),
  .dbg_exit_i(dbg_exit_i), .exc_taken_o(exc_taken_o),
  .handler_pc_o(handler_pc_o), .halt_o(halt_o), .chkstop_o(chkstop_o),
  .wakeup_o(wakeup_o), .dbg_session_o(dbg_session_o)
);

/* File: testbench/exc_irq_source.sv */
// Behavioural external interrupt source.
// Assumes the core clock; one request at a time, started by a pulse.
`timescale 1ns/1ps
module exc_irq_source
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic start_i,
  input wire logic avec_i,
  input wire logic [9:0] ofs_i,
  // From the core
  input wire logic taken_i,
  // Toward the core
  output logic ext_irq_n_o,
  output logic avec_n_o,
  output logic [9:0] voffset_o
);
  logic busy; // Request outstanding
  // Level request held until the core acknowledges it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy <= 1'b0;
      ext_irq_n_o <= 1'b1;
      avec_n_o <= 1'b1;
      voffset_o <= 10'h2aa;
    end
    else if (start_i && !busy)
    begin
      busy <= 1'b1;
      ext_irq_n_o <= 1'b0;
      avec_n_o <= ~avec_i;
      voffset_o <= ofs_i;
    end
    else if (busy && taken_i)
    begin
      // Released qualifiers flip so stale values are never trusted
      busy <= 1'b0;
      ext_irq_n_o <= 1'b1;
      avec_n_o <= ~avec_n_o;
      voffset_o <= ~voffset_o;
    end
  end
endmodule

/* File: testbench/core_exception_entry_unit_test.sv */
// Self-checking bench for the exception entry unit.
// Assumes the constants header on the include path; one 40 MHz clock.
`timescale 1ns/1ps
`include "exc_consts.svh"
module core_exception_entry_unit_test;
  import exc_pkg::*;
  // ==================================================
  // Signals
  localparam word_t PFX = 32'h1234_5000; // Vector prefix under test
  logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
  logic wb_we_i = 0, wb_ack_o, mchk_pin_n_i = 1, dbg_req_i = 0;
  logic dbg_exit_i = 0, ireq = 0, iavec = 0, ext_irq_n_i, avec_n_i;
  logic exc_taken_o, halt_o, chkstop_o, wakeup_o, dbg_session_o;
  logic mchk_out_o, reset_out_n_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [13:0] p = 14'h0000; // Fault pulses, one bit per cause
  logic [9:0] iofs = 10'h000, voffset_i;
  word_t wb_dat_i = 0, wb_dat_o, pc_x = 0, pc_n = 0, da = 0, q;
  word_t handler_pc_o;
  int n_fail = 0, checks_done = 0, cyc = 0, n_taken = 0;
  // ==================================================
  // Clock, timeout and entry counter
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    n_taken += (exc_taken_o === 1'b1);
    if (cyc == 8000)
    begin
      n_fail++;
      complete_run();
    end
  end
  core_exception_entry_unit dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mchk_pin_n_i(mchk_pin_n_i),
    .ext_irq_n_i(ext_irq_n_i), .avec_n_i(avec_n_i), .voffset_i(voffset_i),
    .dbg_req_i(dbg_req_i), .dbg_exit_i(dbg_exit_i), .exc_pc_i(pc_x),
    .next_pc_i(pc_n), .d_addr_i(da), .dacc_viol_i(p[0]), .d_store_i(p[1]),
    .d_varlen_i(p[2]), .align_fault_i(p[3]), .iacc_viol_i(p[4]),
    .imisalign_i(p[5]), .i_varlen_i(p[6]), .store_bus_err_i(p[7]),
    .wdog_second_i(p[8]), .dbyteord_i(p[9]), .dtea_i(p[10]),
    .itea_i(p[11]), .ibyteord_i(p[12]), .handler_fetch_err_i(p[13]),
    .exc_taken_o(exc_taken_o), .handler_pc_o(handler_pc_o),
    .halt_o(halt_o), .chkstop_o(chkstop_o), .wakeup_o(wakeup_o),
    .dbg_session_o(dbg_session_o), .mchk_out_o(mchk_out_o),
    .reset_out_n_o(reset_out_n_o)
  );
  exc_irq_source src
  (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(ireq), .avec_i(iavec),
    .ofs_i(iofs), .taken_i(exc_taken_o), .ext_irq_n_o(ext_irq_n_i),
    .avec_n_o(avec_n_i), .voffset_o(voffset_i)
  );
  // ==================================================
  // Shared tasks
  task automatic cmp(input string s, input word_t e, input word_t g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input word_t d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // No local limit: only ack or the bench timeout ends this wait
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    // Ack must stand for one cycle only
    @(posedge clk_i);
    cmp("ack drop", 32'h0, 32'(wb_ack_o));
  endtask
  task automatic rd(input string s, input logic [7:0] a, input word_t e);
    wb(0, a, 0);
    cmp(s, e, q);
  endtask
  // One-cycle fault pulse; returns after the entry edge settles
  task automatic fire(input logic [13:0] v);
    @(posedge clk_i);
    p <= v;
    @(posedge clk_i);
    p <= 14'h0000;
    #1;
  endtask
  task automatic wait_taken(input int n0);
    for (int k = 0; k < 40 && n_taken == n0; k++)
      @(posedge clk_i);
    #1;
  endtask
  task automatic do_reset(input int k);
    rst_i <= 1;
    repeat (k) @(posedge clk_i);
    rst_i <= 0;
  endtask
  // ==================================================
  // Scenarios
  // Storage and alignment faults, a priority collision, bus errors
  task automatic t_faults();
    logic [13:0] fv [8] = '{14'h0003, 14'h0204, 14'h0060, 14'h000a,
      14'h0011, 14'h0400, 14'h0800, 14'h1000};
    logic [11:0] fo [8] = '{`VOFS_DSI, `VOFS_DSI, `VOFS_ISI, `VOFS_ALIGN,
      `VOFS_ISI, `VOFS_DSI, `VOFS_ISI, `VOFS_ISI};
    word_t fe [8] = '{32'h80_0000, 32'h2_0020, 32'h22, 32'h80_0000, 0,
      32'h1, 32'h1, 32'h2_0000};
    word_t dexp;
    dexp = 0;
    wb(1, `OFS_VPFX, PFX | 32'hfff);
    rd("prefix", `OFS_VPFX, PFX);
    for (int i = 0; i < 8; i++)
    begin
      wb(1, `OFS_MSTATE, 32'hd200);
      pc_x <= 32'h100 + i;
      da <= 32'h200 + i;
      // Bus error terminations leave the data address alone
      if (fo[i] != `VOFS_ISI && !fe[i][`FS_XTE]) dexp = 32'h200 + i;
      fire(fv[i]);
      cmp("taken", 32'h1, 32'(exc_taken_o));
      cmp("vector", PFX | fo[i], handler_pc_o);
      rd("save_pc", `OFS_SPC, 32'h100 + i);
      rd("status", `OFS_FSTAT, fe[i]);
      rd("data_addr", `OFS_FADDR, dexp);
      rd("save_state", `OFS_SSTATE, 32'hd200);
      rd("state", `OFS_MSTATE, 32'h1200);
    end
  endtask
  // External input: held off while disabled, autovectored then vectored
  task automatic t_ext();
    int n0;
    for (int i = 0; i < 2; i++)
    begin
      wb(1, `OFS_MSTATE, 32'h0);
      wb(1, `OFS_FSTAT, 32'h80_0022);
      pc_n <= 32'h400 + i;
      iavec <= (i == 0);
      iofs <= 10'h155;
      ireq <= 1;
      @(posedge clk_i);
      ireq <= 0;
      n0 = n_taken;
      repeat (10) @(posedge clk_i);
      cmp("held off", 32'(n0), 32'(n_taken));
      wb(1, `OFS_MSTATE, 32'h8000);
      wait_taken(n0);
      cmp("ext vector", PFX | (i == 0 ? 32'h40 : 32'h554), handler_pc_o);
      rd("ext save_pc", `OFS_SPC, 32'h400 + i);
      rd("ext save_state", `OFS_SSTATE, 32'h8000);
      rd("ext status", `OFS_FSTAT, 32'h80_0022);
    end
  endtask
  // Machine check from the pin (masked, then enabled) and a store error
  task automatic t_mchk();
    int n0;
    wb(1, `OFS_MSTATE, 32'h1200);
    n0 = n_taken;
    // Pin pulses one cycle: a held level would checkstop once the
    // entry has cleared the enable
    mchk_pin_n_i <= 0;
    @(posedge clk_i);
    mchk_pin_n_i <= 1;
    repeat (8) @(posedge clk_i);
    cmp("pin masked", 32'(n0), 32'(n_taken));
    wb(1, `OFS_DCTL, 32'h2);
    wb(1, `OFS_CFG, 32'h1);
    mchk_pin_n_i <= 0;
    @(posedge clk_i);
    mchk_pin_n_i <= 1;
    wait_taken(n0);
    cmp("pin vector", PFX | `VOFS_MCHK, handler_pc_o);
    rd("de kept", `OFS_MSTATE, 32'h0200);
    rd("pin synd", `OFS_SYND, 32'h1 << `SY_PIN);
    wb(1, `OFS_SYND, 32'hffff_ffff);
    wb(1, `OFS_DCTL, 32'h0);
    wb(1, `OFS_MSTATE, 32'h1200);
    pc_x <= 32'h777;
    fire(14'h0080);
    cmp("mchk taken", 32'h1, 32'(exc_taken_o));
    cmp("mchk vector", PFX | `VOFS_MCHK, handler_pc_o);
    cmp("mchk out", 32'h1, 32'(mchk_out_o));
    rd("crit pc", `OFS_CSPC, 32'h777);
    rd("crit state", `OFS_CSSTATE, 32'h1200);
    rd("mchk state", `OFS_MSTATE, 32'h0);
    rd("synd", `OFS_SYND, 32'h1 << `SY_WRERR);
    rd("fault_data_addr_reg kept", `OFS_FADDR, 32'h203);
    wb(1, `OFS_SYND, 32'hffff_ffff);
    cmp("mchk out low", 32'h0, 32'(mchk_out_o));
  endtask
  // Checkstop, debug escape and return, reset out, watchdog
  task automatic t_stop();
    fire(14'h2080);
    cmp("chkstop", 32'h1, 32'(chkstop_o));
    rd("chk synd", `OFS_SYND, 32'h0800_0004);
    fire(14'h0001);
    cmp("no entry", 32'h0, 32'(exc_taken_o));
    @(posedge clk_i);
    dbg_req_i <= 1;
    // Two synchroniser edges, then look off the edge
    repeat (2) @(posedge clk_i);
    #1;
    cmp("wakeup", 32'h1, 32'(wakeup_o));
    @(posedge clk_i);
    dbg_req_i <= 0;
    #1;
    cmp("debug", 32'h1, 32'(dbg_session_o));
    cmp("chk low", 32'h0, 32'(chkstop_o));
    repeat (3) @(posedge clk_i);
    dbg_exit_i <= 1;
    @(posedge clk_i);
    dbg_exit_i <= 0;
    #1;
    cmp("chk back", 32'h1, 32'(chkstop_o));
    wb(1, `OFS_DCTL, 32'h1);
    cmp("reset out", 32'h0, 32'(reset_out_n_o));
    do_reset(3);
    #1;
    cmp("after reset", 32'h0, 32'(chkstop_o));
    wb(1, `OFS_TCTL, 32'h1000_0000);
    fire(14'h0100);
    cmp("wdog stop", 32'h1, 32'(chkstop_o));
  endtask
  // ==================================================
  // Main sequence and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    do_reset(20);
    t_faults();
    t_ext();
    t_mchk();
    t_stop();
    complete_run();
  end
endmodule
